// ### hdl/tcu_regs.vh
`ifndef TCU_REGS_VH
`define TCU_REGS_VH

// register byte offsets on the bus
`define TCU_OFF_PIN_FUNC 6'h00
`define TCU_OFF_RUN_CTRL 6'h04
`define TCU_OFF_CTRL0 6'h08
`define TCU_OFF_CTRL1 6'h0c
`define TCU_OFF_CTRL2 6'h10
`define TCU_OFF_RELOAD0 6'h14
`define TCU_OFF_RELOAD1 6'h18
`define TCU_OFF_RELOAD2 6'h1c
`define TCU_OFF_COUNT0 6'h20
`define TCU_OFF_COUNT1 6'h24
`define TCU_OFF_COUNT2 6'h28
`define TCU_OFF_CAPTURE 6'h2c
`define TCU_OFF_IRQ_STATUS 6'h30
`define TCU_OFF_IRQ_CLEAR 6'h34
`define TCU_OFF_IRQ_ENABLE 6'h38

// channel control and pin function field positions
`define TCU_SEL_LSB 0
`define TCU_EDGE_LSB 3
`define TCU_UNDERFLOW_IRQ_ENABLE_BIT 5
`define TCU_CAPCTL_LSB 6
`define TCU_UNF_BIT 8
`define TCU_CAPF_BIT 9
`define TCU_PIN_SEL_BIT 0

// interrupt status layout
`define TCU_IRQ_CAP_BIT 3
`define TCU_IRQ_W 4

// reset values
`define TCU_PIN_FUNC_RST 8'h00
`define TCU_RUN_CTRL_RST 8'h00
`define TCU_CTRL_RST 16'h0000
`define TCU_RELOAD_RST 32'hffffffff
`define TCU_COUNT_RST 32'hffffffff

// count clock select codes
`define TCU_SEL_RTC 3'h4
`define TCU_SEL_PIN 3'h5

// prescaler divide shifts: /4 /16 /64 /256
`define TCU_PRESC_W 8

// axi responses
`define TCU_RESP_OKAY 2'h0
`define TCU_RESP_SLVERR 2'h2

`endif

// ### hdl/tcu_prescale.v
`include "tcu_regs.vh"

module tcu_prescale (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // one-cycle ticks at /4, /16, /64, /256
   output wire [3:0] o_tick
);

   reg [`TCU_PRESC_W-1:0] cnt_reg;

   always @(posedge i_clk) begin
      if (i_srst) begin
         cnt_reg <= {`TCU_PRESC_W{1'b0}};
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_tick
         assign o_tick[g] = &cnt_reg[2*g+1:0];
      end
   endgenerate

endmodule

// ### hdl/tcu_channel.v
`include "tcu_regs.vh"

module tcu_channel (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // control
   input wire i_run,
   input wire [2:0] i_sel,
   input wire [1:0] i_edge,
   // count sources
   input wire [3:0] i_presc_tick,
   input wire i_rtc_rise,
   input wire i_pin_rise,
   input wire i_pin_fall,
   // software access
   input wire [31:0] i_reload,
   input wire i_load,
   input wire [31:0] i_load_data,
   // state
   output reg [31:0] o_count,
   output reg o_underflow
);

   reg tick;
   reg pin_edge;

   always @* begin
      pin_edge = i_edge[1] ? (i_pin_rise | i_pin_fall) :
                 (i_edge[0] ? i_pin_fall : i_pin_rise);
      case (i_sel)
         3'h0, 3'h1, 3'h2, 3'h3: tick = i_presc_tick[i_sel[1:0]];
         `TCU_SEL_RTC: tick = i_rtc_rise;
         `TCU_SEL_PIN: tick = pin_edge;
         default: tick = 1'b0; // reserved codes never count
      endcase
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         o_count <= `TCU_COUNT_RST;
         o_underflow <= 1'b0;
      end else begin
         o_underflow <= 1'b0;
         if (i_load) begin
            o_count <= i_load_data;
         end else if (i_run && tick) begin
            if (o_count == 32'h00000000) begin
               o_count <= i_reload;
               o_underflow <= 1'b1;
            end else begin
               o_count <= o_count - 32'h00000001;
            end
         end
      end
   end

endmodule

// ### hdl/tcu_top.v
`include "tcu_regs.vh"

module tcu_top (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // axi4-lite write address and data
   input wire i_axi_awvalid,
   output wire o_axi_awready,
   input wire [5:0] i_axi_awaddr,
   input wire i_axi_wvalid,
   output wire o_axi_wready,
   input wire [31:0] i_axi_wdata,
   input wire [3:0] i_axi_wstrb,
   // axi4-lite write response
   output wire o_axi_bvalid,
   input wire i_axi_bready,
   output wire [1:0] o_axi_bresp,
   // axi4-lite read
   input wire i_axi_arvalid,
   output wire o_axi_arready,
   input wire [5:0] i_axi_araddr,
   output wire o_axi_rvalid,
   input wire i_axi_rready,
   output wire [31:0] o_axi_rdata,
   output wire [1:0] o_axi_rresp,
   // timer clock pin, output enable low while driving
   input wire i_timer_clock_pin,
   output wire o_timer_clock_pin,
   output wire o_timer_clock_pin_oe_n,
   // rtc tick clock, asynchronous
   input wire i_rtc_tick_clock,
   // standby controls from system control
   input wire i_standby,
   input wire i_pll_ratio_change,
   input wire i_timer_module_stop,
   // interrupts
   output wire o_irq,
   output wire [2:0] o_underflow_interrupt,
   output wire o_capture_interrupt
);

   // axi state
   reg awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   reg aw_held_reg, w_held_reg;
   reg [5:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg [1:0] bresp_reg, rresp_reg;
   reg [31:0] rdata_reg;
   // registers
   reg pin_output_select_reg;
   reg [2:0] run_reg;
   reg [8:0] sel_reg;
   reg [5:0] edge_reg;
   reg [2:0] underflow_irq_enable_reg;
   reg [2:0] underflow_flag_reg;
   reg [1:0] capture_control_reg;
   reg capture_flag_reg;
   reg [95:0] reload_reg;
   reg [31:0] capture_value_reg;
   reg [`TCU_IRQ_W-1:0] irq_status_reg, irq_enable_reg;
   // pin synchronisers
   reg pin_s1_reg, pin_s2_reg, pin_s3_reg;
   reg rtc_s1_reg, rtc_s2_reg, rtc_s3_reg;
   // outputs
   reg pin_out_reg, pin_oe_n_reg, irq_reg, cap_irq_reg;
   reg [2:0] unf_irq_reg;

   wire aw_take = i_axi_awvalid & awready_reg;
   wire w_take = i_axi_wvalid & wready_reg;
   wire ar_take = i_axi_arvalid & arready_reg;
   wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire aw_held_next = aw_take | (aw_held_reg & ~wr_fire);
   wire w_held_next = w_take | (w_held_reg & ~wr_fire);
   wire rvalid_next = ar_take | (rvalid_reg & ~i_axi_rready);
   // a pending response keeps both readies low so no second write slips in
   wire bvalid_next = wr_fire | (bvalid_reg & ~i_axi_bready);
   wire [7:0] pin_func_rst = `TCU_PIN_FUNC_RST, run_ctrl_rst = `TCU_RUN_CTRL_RST;
   wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire [31:0] wmd = wdata_reg & wmask;

   // write decode
   wire [5:0] wa = awaddr_reg;
   wire wr_pin = wr_fire & (wa == `TCU_OFF_PIN_FUNC);
   wire wr_run = wr_fire & (wa == `TCU_OFF_RUN_CTRL);
   wire wr_clr = wr_fire & (wa == `TCU_OFF_IRQ_CLEAR);
   wire wr_ena = wr_fire & (wa == `TCU_OFF_IRQ_ENABLE);
   wire [2:0] wr_ctrl, wr_rel, wr_cnt;
   wire wr_known = wr_pin | wr_run | wr_clr | wr_ena | (|wr_ctrl) | (|wr_rel) |
                   (|wr_cnt) | (wa == `TCU_OFF_CAPTURE) |
                   (wa == `TCU_OFF_IRQ_STATUS);

   // pin edges taken between the second and third stages, never on the first
   wire pin_is_input = ~pin_output_select_reg;
   wire pin_rise = pin_is_input & pin_s2_reg & ~pin_s3_reg;
   wire pin_fall = pin_is_input & ~pin_s2_reg & pin_s3_reg;
   wire rtc_rise = rtc_s2_reg & ~rtc_s3_reg;

   wire [3:0] presc_tick;
   wire [95:0] count;
   wire [2:0] uf_pulse;
   wire [2:0] std_clr;

   tcu_prescale u_presc (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .o_tick(presc_tick)
   );

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ch
         assign wr_ctrl[g] = wr_fire & (wa == `TCU_OFF_CTRL0 + 6'h04 * g);
         assign wr_rel[g] = wr_fire & (wa == `TCU_OFF_RELOAD0 + 6'h04 * g);
         assign wr_cnt[g] = wr_fire & (wa == `TCU_OFF_COUNT0 + 6'h04 * g);
         // rtc-clocked channels keep running through standby
         assign std_clr[g] = i_standby & (i_pll_ratio_change | i_timer_module_stop) &
                             (sel_reg[3*g+2:3*g] != `TCU_SEL_RTC);
         tcu_channel u_ch (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_run(run_reg[g]),
            .i_sel(sel_reg[3*g+2:3*g]),
            .i_edge(edge_reg[2*g+1:2*g]),
            .i_presc_tick(presc_tick),
            .i_rtc_rise(rtc_rise),
            .i_pin_rise(pin_rise),
            .i_pin_fall(pin_fall),
            .i_reload(reload_reg[32*g+31:32*g]),
            .i_load(wr_cnt[g]),
            .i_load_data((count[32*g+31:32*g] & ~wmask) | wmd),
            .o_count(count[32*g+31:32*g]),
            .o_underflow(uf_pulse[g])
         );
      end
   endgenerate

   // capture on channel two, edge chosen by its own edge field
   wire cap_edge = edge_reg[5] ? (pin_rise | pin_fall) :
                   (edge_reg[4] ? pin_fall : pin_rise);
   wire cap_event = capture_control_reg[1] & cap_edge;
   wire [`TCU_IRQ_W-1:0] irq_events = {cap_event, uf_pulse};

   // axi handshake
   always @(posedge i_clk) begin
      if (i_srst) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         arready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         awaddr_reg <= 6'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bresp_reg <= `TCU_RESP_OKAY;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= ~aw_held_next & ~bvalid_next;
         wready_reg <= ~w_held_next & ~bvalid_next;
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (aw_take) begin
            awaddr_reg <= {i_axi_awaddr[5:2], 2'b00};
         end
         if (w_take) begin
            wdata_reg <= i_axi_wdata;
            wstrb_reg <= i_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
         end else if (i_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // read data, one word per register, reserved bits zero
   reg [31:0] rd;
   reg rd_ok;
   always @* begin
      rd = 32'h00000000;
      rd_ok = 1'b1;
      case ({i_axi_araddr[5:2], 2'b00})
         `TCU_OFF_PIN_FUNC: rd[`TCU_PIN_SEL_BIT] = pin_output_select_reg;
         `TCU_OFF_RUN_CTRL: rd[2:0] = run_reg;
         `TCU_OFF_CTRL0: rd[9:0] = {1'b0, underflow_flag_reg[0], 2'b00,
                                    underflow_irq_enable_reg[0], edge_reg[1:0], sel_reg[2:0]};
         `TCU_OFF_CTRL1: rd[9:0] = {1'b0, underflow_flag_reg[1], 2'b00,
                                    underflow_irq_enable_reg[1], edge_reg[3:2], sel_reg[5:3]};
         `TCU_OFF_CTRL2: rd[9:0] = {capture_flag_reg, underflow_flag_reg[2],
                                    capture_control_reg, underflow_irq_enable_reg[2],
                                    edge_reg[5:4], sel_reg[8:6]};
         `TCU_OFF_RELOAD0: rd = reload_reg[31:0];
         `TCU_OFF_RELOAD1: rd = reload_reg[63:32];
         `TCU_OFF_RELOAD2: rd = reload_reg[95:64];
         `TCU_OFF_COUNT0: rd = count[31:0];
         `TCU_OFF_COUNT1: rd = count[63:32];
         `TCU_OFF_COUNT2: rd = count[95:64];
         `TCU_OFF_CAPTURE: rd = capture_value_reg;
         `TCU_OFF_IRQ_STATUS: rd[`TCU_IRQ_W-1:0] = irq_status_reg;
         `TCU_OFF_IRQ_CLEAR: rd = 32'h00000000;
         `TCU_OFF_IRQ_ENABLE: rd[`TCU_IRQ_W-1:0] = irq_enable_reg;
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         rdata_reg <= 32'h00000000;
         rresp_reg <= `TCU_RESP_OKAY;
      end else if (ar_take) begin
         rdata_reg <= rd;
         rresp_reg <= rd_ok ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
      end
   end

   // control and status registers
   integer i;
   always @(posedge i_clk) begin
      if (i_srst) begin
         pin_output_select_reg <= pin_func_rst[`TCU_PIN_SEL_BIT];
         run_reg <= run_ctrl_rst[2:0];
         sel_reg <= 9'h000;
         edge_reg <= 6'h00;
         underflow_irq_enable_reg <= 3'h0;
         underflow_flag_reg <= 3'h0;
         capture_control_reg <= 2'h0;
         capture_flag_reg <= 1'b0;
         reload_reg <= {3{`TCU_RELOAD_RST}};
         capture_value_reg <= 32'h00000000;
         irq_status_reg <= {`TCU_IRQ_W{1'b0}};
         irq_enable_reg <= {`TCU_IRQ_W{1'b0}};
      end else begin
         // only the low bit is stored, upper bits ignored
         if (wr_pin && wstrb_reg[0]) begin
            pin_output_select_reg <= wdata_reg[`TCU_PIN_SEL_BIT];
         end
         for (i = 0; i < 3; i = i + 1) begin
            if (std_clr[i]) begin
               run_reg[i] <= 1'b0;
            end else if (wr_run && wstrb_reg[0]) begin
               run_reg[i] <= wdata_reg[i];
            end
            if (wr_ctrl[i] && wstrb_reg[0]) begin
               sel_reg[3*i +: 3] <= wdata_reg[`TCU_SEL_LSB +: 3];
               edge_reg[2*i +: 2] <= wdata_reg[`TCU_EDGE_LSB +: 2];
               underflow_irq_enable_reg[i] <= wdata_reg[`TCU_UNDERFLOW_IRQ_ENABLE_BIT];
            end
            // a new underflow wins over a clearing write
            underflow_flag_reg[i] <= uf_pulse[i] | (underflow_flag_reg[i] &
               ~(wr_ctrl[i] & wstrb_reg[1] & ~wdata_reg[`TCU_UNF_BIT]));
            if (wr_rel[i]) begin
               reload_reg[32*i +: 32] <= (reload_reg[32*i +: 32] & ~wmask) | wmd;
            end
         end
         if (wr_ctrl[2] && wstrb_reg[0]) begin
            capture_control_reg <= wdata_reg[`TCU_CAPCTL_LSB +: 2];
         end
         capture_flag_reg <= cap_event | (capture_flag_reg &
            ~(wr_ctrl[2] & wstrb_reg[1] & ~wdata_reg[`TCU_CAPF_BIT]));
         if (cap_event) begin
            capture_value_reg <= count[95:64];
         end
         irq_status_reg <= irq_events |
            (irq_status_reg & ~(wr_clr ? wmd[`TCU_IRQ_W-1:0] : {`TCU_IRQ_W{1'b0}}));
         if (wr_ena) begin
            irq_enable_reg <= (irq_enable_reg & ~wmask[`TCU_IRQ_W-1:0]) |
                              wmd[`TCU_IRQ_W-1:0];
         end
      end
   end

   // pin synchronisers and registered outputs
   always @(posedge i_clk) begin
      if (i_srst) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
         rtc_s1_reg <= 1'b0;
         rtc_s2_reg <= 1'b0;
         rtc_s3_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_n_reg <= 1'b1;
         irq_reg <= 1'b0;
         unf_irq_reg <= 3'h0;
         cap_irq_reg <= 1'b0;
      end else begin
         pin_s1_reg <= i_timer_clock_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         rtc_s1_reg <= i_rtc_tick_clock;
         rtc_s2_reg <= rtc_s1_reg;
         rtc_s3_reg <= rtc_s2_reg;
         pin_out_reg <= rtc_s2_reg;
         pin_oe_n_reg <= ~pin_output_select_reg;
         irq_reg <= |(irq_status_reg & irq_enable_reg);
         unf_irq_reg <= underflow_flag_reg & underflow_irq_enable_reg;
         cap_irq_reg <= capture_flag_reg & (capture_control_reg == 2'h3);
      end
   end

   assign o_axi_awready = awready_reg;
   assign o_axi_wready = wready_reg;
   assign o_axi_bvalid = bvalid_reg;
   assign o_axi_bresp = bresp_reg;
   assign o_axi_arready = arready_reg;
   assign o_axi_rvalid = rvalid_reg;
   assign o_axi_rdata = rdata_reg;
   assign o_axi_rresp = rresp_reg;
   assign o_timer_clock_pin = pin_out_reg;
   assign o_timer_clock_pin_oe_n = pin_oe_n_reg;
   assign o_irq = irq_reg;
   assign o_underflow_interrupt = unf_irq_reg;
   assign o_capture_interrupt = cap_irq_reg;

endmodule

// ### dv/tcu_top_assertions.sv
`include "tcu_regs.vh"

module tcu_top_assertions (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // bus requests
   input wire i_axi_awvalid,
   input wire i_axi_wvalid,
   input wire i_axi_bready,
   input wire i_axi_arvalid,
   input wire [5:0] i_axi_araddr,
   input wire i_axi_rready,
   // bus answers
   input wire o_axi_awready,
   input wire o_axi_wready,
   input wire o_axi_bvalid,
   input wire [1:0] o_axi_bresp,
   input wire o_axi_arready,
   input wire o_axi_rvalid,
   input wire [31:0] o_axi_rdata,
   input wire [1:0] o_axi_rresp,
   // pin
   input wire o_timer_clock_pin_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_wr_take;
      i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
   endsequence
   sequence s_rd_at(logic [5:0] a);
      i_axi_arvalid && o_axi_arready && (i_axi_araddr[5:2] == a[5:2]);
   endsequence
   sequence s_rd_take;
      i_axi_arvalid && o_axi_arready;
   endsequence

   a_write_answered: assert property (s_wr_take |-> ##[1:2] o_axi_bvalid)
      else $error("write response missing");
   a_read_answered: assert property (s_rd_take |=> o_axi_rvalid)
      else $error("read data missing");
   a_bresp_held: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
      else $error("write response dropped");
   a_rdata_held: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
      else $error("read data dropped");
   a_no_new_write: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
      else $error("write accepted while response pending");
   a_pin_reserved_zero: assert property (s_rd_at(`TCU_OFF_PIN_FUNC) |=> o_axi_rdata[31:1] == 31'h0)
      else $error("pin function reserved bits nonzero");
   a_run_reserved_zero: assert property (s_rd_at(`TCU_OFF_RUN_CTRL) |=> o_axi_rdata[31:3] == 29'h0)
      else $error("run control reserved bits nonzero");
   a_ctrl_reserved_zero: assert property (s_rd_at(`TCU_OFF_CTRL0) or s_rd_at(`TCU_OFF_CTRL1)
      |=> o_axi_rdata[31:9] == 23'h0 && o_axi_rdata[7:6] == 2'h0)
      else $error("channel control reserved bits nonzero");
   a_unmapped_error: assert property (s_rd_at(6'h3c) |=> o_axi_rresp == `TCU_RESP_SLVERR
      && o_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_reset_quiet: assert property (disable iff (1'b0) i_srst |=> !o_axi_bvalid && !o_axi_rvalid
      && o_timer_clock_pin_oe_n)
      else $error("outputs active after reset");
endmodule

bind tcu_top tcu_top_assertions u_tcu_top_assertions (
   .i_clk(i_clk), .i_srst(i_srst), .i_axi_awvalid(i_axi_awvalid), .i_axi_wvalid(i_axi_wvalid),
   .i_axi_bready(i_axi_bready), .i_axi_arvalid(i_axi_arvalid), .i_axi_araddr(i_axi_araddr),
   .i_axi_rready(i_axi_rready), .o_axi_awready(o_axi_awready), .o_axi_wready(o_axi_wready),
   .o_axi_bvalid(o_axi_bvalid), .o_axi_bresp(o_axi_bresp), .o_axi_arready(o_axi_arready),
   .o_axi_rvalid(o_axi_rvalid), .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp),
   .o_timer_clock_pin_oe_n(o_timer_clock_pin_oe_n)
);

// ### dv/tcu_tb_top.sv
`include "tcu_regs.vh"

module tcu_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
   logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
   logic [5:0] i_axi_awaddr = 6'h00, i_axi_araddr = 6'h00;
   logic [31:0] i_axi_wdata = 32'h0;
   logic pin_in = 1'b0, standby = 1'b0, pll_change = 1'b0, mod_stop = 1'b0;
   logic rtc = 1'b0;
   logic [3:0] wstrb = 4'hf;
   wire o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
   wire [1:0] o_axi_bresp, o_axi_rresp;
   wire [31:0] o_axi_rdata;
   wire pin_out, pin_oe_n, irq, cap_irq;
   wire [2:0] unf_irq;
   int err_count = 0, n_tests = 0, cyc = 0;
   logic [31:0] rd_data;
   logic [1:0] rd_resp, wr_resp;
   logic [5:0] offs [5] = '{`TCU_OFF_CTRL0, `TCU_OFF_CTRL1, `TCU_OFF_CTRL2, `TCU_OFF_PIN_FUNC,
      `TCU_OFF_RUN_CTRL};
   logic [31:0] msk [5] = '{32'h3f, 32'h3f, 32'hff, 32'h01, 32'h07};
   logic [1:0] cc [3] = '{2'h0, 2'h2, 2'h3};

   tcu_top u_tcu_top (
      .i_clk(i_clk), .i_srst(i_srst),
      .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready), .i_axi_awaddr(i_axi_awaddr),
      .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .i_axi_wdata(i_axi_wdata),
      .i_axi_wstrb(wstrb), .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready),
      .o_axi_bresp(o_axi_bresp), .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready),
      .i_axi_araddr(i_axi_araddr), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
      .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp),
      .i_timer_clock_pin(pin_in), .o_timer_clock_pin(pin_out), .o_timer_clock_pin_oe_n(pin_oe_n),
      .i_rtc_tick_clock(rtc), .i_standby(standby), .i_pll_ratio_change(pll_change),
      .i_timer_module_stop(mod_stop), .o_irq(irq), .o_underflow_interrupt(unf_irq),
      .o_capture_interrupt(cap_irq)
   );

   initial begin
      forever #2.5 i_clk = ~i_clk;
   end

   task test_done;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // a hang in any handshake loop ends here rather than running forever
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         $display("[ERR] watchdog expected finish seen hang");
         test_done;
      end
   end

   task chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task chk_bit(input string nm, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bit ad = 0;
      bit wd = 0;
      @(posedge i_clk);
      i_axi_awvalid <= 1'b1;
      i_axi_wvalid <= 1'b1;
      i_axi_awaddr <= a;
      i_axi_wdata <= d;
      i_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge i_clk);
         if (o_axi_awready && i_axi_awvalid) begin
            ad = 1;
            i_axi_awvalid <= 1'b0;
         end
         if (o_axi_wready && i_axi_wvalid) begin
            wd = 1;
            i_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge i_clk); while (o_axi_bvalid !== 1'b1);
      wr_resp = o_axi_bresp;
      i_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a);
      @(posedge i_clk);
      i_axi_arvalid <= 1'b1;
      i_axi_araddr <= a;
      i_axi_rready <= 1'b1;
      do @(posedge i_clk); while (o_axi_arready !== 1'b1);
      i_axi_arvalid <= 1'b0;
      do @(posedge i_clk); while (o_axi_rvalid !== 1'b1);
      rd_data = o_axi_rdata;
      rd_resp = o_axi_rresp;
      i_axi_rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string nm);
      rd(a);
      chk_word(nm, exp, rd_data);
   endtask

   initial begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      for (int i = 0; i < 5; i++)
         rd_chk(offs[i], 32'h0, "reset value");
      $display("test reset values done");
      // all clock selects land on 7, so the run bits set below never count
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], 32'hffffffff);
         rd_chk(offs[i], msk[i], "reserved bits");
      end
      rtc <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk_bit("pin drive enable", 1'h0, pin_oe_n);
      chk_bit("rtc clock out", 1'h1, pin_out);
      rtc <= 1'b0;
      wr(`TCU_OFF_PIN_FUNC, 32'h0);
      repeat (4) @(posedge i_clk);
      chk_bit("pin drive release", 1'h1, pin_oe_n);
      wr(6'h3c, 32'h1);
      chk_word("unmapped write resp", 32'h2, {30'h0, wr_resp});
      rd(6'h3c);
      chk_word("unmapped read resp", 32'h2, {30'h0, rd_resp});
      $display("test register access done");
      wr(`TCU_OFF_CTRL0, 32'h04);
      for (int k = 0; k < 2; k++) begin
         wr(`TCU_OFF_RUN_CTRL, 32'h7);
         @(posedge i_clk);
         standby <= 1'b1;
         pll_change <= (k == 0);
         mod_stop <= (k == 1);
         @(posedge i_clk);
         standby <= 1'b0;
         pll_change <= 1'b0;
         mod_stop <= 1'b0;
         rd_chk(`TCU_OFF_RUN_CTRL, 32'h1, "run after standby");
      end
      wr(`TCU_OFF_RUN_CTRL, 32'h0);
      $display("test standby done");
      wr(`TCU_OFF_RELOAD0, 32'h5);
      wr(`TCU_OFF_COUNT0, 32'h2);
      wr(`TCU_OFF_CTRL0, 32'h20);
      wr(`TCU_OFF_RUN_CTRL, 32'h1);
      while (unf_irq[0] !== 1'b1) @(posedge i_clk);
      wr(`TCU_OFF_RUN_CTRL, 32'h0);
      rd_chk(`TCU_OFF_CTRL0, 32'h120, "underflow flag set");
      rd(`TCU_OFF_COUNT0);
      chk_bit("counter reloaded", 1'h1, rd_data <= 32'h5);
      rd_chk(`TCU_OFF_IRQ_STATUS, 32'h1, "irq status");
      chk_bit("irq masked", 1'h0, irq);
      wr(`TCU_OFF_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge i_clk);
      chk_bit("irq raised", 1'h1, irq);
      wr(`TCU_OFF_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge i_clk);
      chk_bit("irq cleared", 1'h0, irq);
      rd_chk(`TCU_OFF_IRQ_STATUS, 32'h0, "irq status cleared");
      // low byte lane only: the flag byte is not written, so the flag stays
      wstrb <= 4'h1;
      wr(`TCU_OFF_CTRL0, 32'h20);
      wstrb <= 4'hf;
      rd_chk(`TCU_OFF_CTRL0, 32'h120, "underflow flag lane");
      wr(`TCU_OFF_CTRL0, 32'h120);
      rd_chk(`TCU_OFF_CTRL0, 32'h120, "underflow flag kept");
      wr(`TCU_OFF_CTRL0, 32'h20);
      rd_chk(`TCU_OFF_CTRL0, 32'h20, "underflow flag cleared");
      chk_bit("underflow int low", 1'h0, unf_irq[0]);
      $display("test underflow done");
      for (int k = 0; k < 3; k++) begin
         wr(`TCU_OFF_CTRL2, {24'h0, cc[k], 6'h00});
         @(posedge i_clk);
         pin_in <= 1'b0;
         repeat (6) @(posedge i_clk);
         pin_in <= 1'b1;
         repeat (6) @(posedge i_clk);
         rd_chk(`TCU_OFF_CTRL2, {22'h0, cc[k] != 2'h0, 1'b0, cc[k], 6'h00}, "capture flag");
         chk_bit("capture int", cc[k] == 2'h3, cap_irq);
         wr(`TCU_OFF_CTRL2, {22'h0, 2'h2, cc[k], 6'h00});
         rd_chk(`TCU_OFF_CTRL2, {22'h0, cc[k] != 2'h0, 1'b0, cc[k], 6'h00}, "flag one write");
         wr(`TCU_OFF_CTRL2, {24'h0, cc[k], 6'h00});
         rd_chk(`TCU_OFF_CTRL2, {24'h0, cc[k], 6'h00}, "flag zero write");
      end
      rd_chk(`TCU_OFF_CAPTURE, `TCU_COUNT_RST, "capture value");
      $display("test capture done");
      test_done;
   end
endmodule
